/* File: rtl/clock_gen_pkg.sv */
// Constants, register layouts and state codes for the clock generator.
package clock_gen_pkg;

	// ==========================================================
	// Register map: indices as printed, byte address is four times.
	localparam int unsigned   ADDR_W        = 18;
	localparam logic [15:0]   IDX_DIV_MODE  = 16'hf002;
	localparam logic [15:0]   IDX_EN_SEL    = 16'hf003;

	typedef struct packed {
		logic [1:0] rsvd;
		logic [1:0] out_div;
		logic       src_fixed;
		logic       src_ext;
		logic [1:0] sys_div;
	} div_mode_t;

	typedef struct packed {
		logic       lock;
		logic [4:0] rsvd;
		logic       enable;
		logic       select;
	} en_sel_t;

	localparam logic [7:0]    DIV_MODE_RST  = 8'h3b;
	localparam logic [7:0]    EN_SEL_RST    = 8'h00;
	localparam logic [1:0]    DIV_1         = 2'h0;
	localparam logic [1:0]    DIV_2         = 2'h1;
	localparam logic [1:0]    DIV_4         = 2'h2;
	localparam logic [1:0]    DIV_8         = 2'h3;

	// ==========================================================
	// Stabilisation counts in oscillator pulses.
	localparam logic [8:0]    LS_RESET_WAIT = 9'h100;
	localparam logic [8:0]    LS_WAKE_WAIT  = 9'h020;
	localparam logic [13:0]   EXT_WAIT      = 14'h0080;
	localparam logic [13:0]   PLL_WAIT_DEF  = 14'h2000;

	// PLL gain and the one percent lock window around it.
	localparam logic [9:0]    PLL_MULT      = 10'h200;
	localparam logic [9:0]    LOCK_TOL      = 10'h005;
	localparam logic [9:0]    LOCK_LO       = PLL_MULT - LOCK_TOL;
	localparam logic [9:0]    LOCK_HI       = PLL_MULT + LOCK_TOL;

	// ==========================================================
	// Bus answers and switch states.
	localparam logic [1:0]    RESP_OKAY     = 2'h0;
	localparam logic [1:0]    RESP_DECERR   = 2'h3;

	typedef enum logic [2:0] {
		SW_LS   = 3'b001,
		SW_HS   = 3'b010,
		SW_PARK = 3'b100
	} sw_state_t;

endpackage

/* File: rtl/clock_gen.sv */
// Clock generation, selection and stabilisation with an AXI4-Lite slave.
// How it works
// - Reset runs system clock from low-speed oscillator.
// - System divider codes 1/2/4/8, PLL code0 halves.
// - Mode bit writable only while oscillator disabled.
// - Mode bit 2: 0 PLL, 1 external pin.
// - Fixed upper mode bit always reads one.
// - Output divider bits 5:4 select 1/2/4/8.
// - Port-A pin wins over port-B pin.
// - Select bit forced zero while oscillator disabled.
// - Select bit 0: low-speed, 1: high-speed.
// - Enable bit 1 starts/stops fast oscillator.
// - Lock bit 7 high only when PLL within tolerance.
// - Reset start waits 256 low-speed pulses.
// - Stop wake waits 32 low-speed pulses.
// - Low-speed oscillator halts in stop, wakes on interrupt.
// - Power-on, port or watchdog reset start oscillator.
// - PLL mode waits 8192 PLL pulses.
// - PLL multiplies low-speed reference by 512.
// - PLL mode leaves both clock pins free.
// - First register: byte access or word with second.
// - External mode waits 128 input pulses.
// - Fast oscillator stops in stop, recounts on wake.
module clock_gen
	import clock_gen_pkg::*;
#(
	parameter logic [13:0] PLL_WAIT = PLL_WAIT_DEF
)(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              lsosc_pin,
	input  wire logic              pll_pin,
	input  wire logic              external_clock_input_a_pin,
	input  wire logic              external_clock_input_b_pin,
	input  wire logic              external_clock_input_a_cfg,
	input  wire logic              external_clock_input_b_cfg,
	input  wire logic              sys_reset,
	input  wire logic              stop_req,
	input  wire logic              wake_irq,
	output logic                   lsosc_run,
	output logic                   pll_run,
	output logic                   external_clock_input_a_taken,
	output logic                   external_clock_input_b_taken,
	output logic                   low_speed_clock,
	output logic                   high_speed_clock,
	output logic                   fast_output_clock,
	output logic                   system_clock,
	output logic                   cpu_hold
);

	// ==========================================================
	// Pin synchronisers and edge detection.
	logic [3:0] pin_raw;
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [3:0] rise;

	assign pin_raw = {external_clock_input_b_pin, external_clock_input_a_pin, pll_pin, lsosc_pin};

	for (genvar i = 0; i < 4; i++)
	begin : g_sync
		always_ff @(posedge clock or negedge rst_b)
		begin
			if (!rst_b)
			begin
				sync1_r[i] <= 1'b0;
				sync2_r[i] <= 1'b0;
				prev_r[i]  <= 1'b0;
			end
			else
			begin
				sync1_r[i] <= pin_raw[i];
				sync2_r[i] <= sync1_r[i];
				prev_r[i]  <= sync2_r[i];
			end
		end
		assign rise[i] = sync2_r[i] & ~prev_r[i];
	end

	// ==========================================================
	// Registers and AXI4-Lite slave.
	div_mode_t   dm_r;
	logic        enable_r;
	logic        select_r;
	logic        lock_r;
	logic [15:0] aw_idx_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        wr_fire;
	logic [15:0] wr_idx;
	logic        dm_we;
	logic        es_we;
	logic [7:0]  es_wd;
	logic        wr_hit;
	logic [15:0] rd_idx;
	logic [7:0]  dm_rd;
	logic [7:0]  es_rd;

	assign wr_fire = !awready && !wready && !bvalid;
	assign wr_idx  = aw_idx_r;
	// A word write at the first index also carries the second byte.
	assign dm_we   = (wr_idx == IDX_DIV_MODE) && wstrb_r[0];
	assign es_we   = ((wr_idx == IDX_DIV_MODE) && wstrb_r[1]) ||
	                 ((wr_idx == IDX_EN_SEL) && wstrb_r[0]);
	assign es_wd   = (wr_idx == IDX_DIV_MODE) ? wdata_r[15:8] : wdata_r[7:0];
	assign wr_hit  = (wr_idx == IDX_DIV_MODE) || (wr_idx == IDX_EN_SEL);
	assign rd_idx  = araddr[ADDR_W-1:2];
	assign dm_rd   = {2'b00, dm_r.out_div, 1'b1, dm_r.src_ext,
	                  dm_r.sys_div};
	assign es_rd   = {lock_r, 5'h00, enable_r, select_r};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			aw_idx_r <= 16'h0000;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awready  <= 1'b0;
				aw_idx_r <= awaddr[ADDR_W-1:2];
			end
			if (wvalid && wready)
			begin
				wready  <= 1'b0;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (wr_fire)
			begin
				bvalid <= 1'b1;
				bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
			end
			if (bvalid && bready)
			begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rresp   <= RESP_OKAY;
			rdata   <= 32'h0000_0000;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			if (rd_idx == IDX_DIV_MODE)
			begin
				rdata <= {16'h0000, es_rd, dm_rd};
				rresp <= RESP_OKAY;
			end
			else if (rd_idx == IDX_EN_SEL)
			begin
				rdata <= {24'h00_0000, es_rd};
				rresp <= RESP_OKAY;
			end
			else
			begin
				rdata <= 32'h0000_0000;
				rresp <= RESP_DECERR;
			end
		end
		else if (rvalid && rready)
		begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// A port or watchdog reset restores the registers like power-on.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			dm_r <= div_mode_t'(DIV_MODE_RST);
		else if (sys_reset)
			dm_r <= div_mode_t'(DIV_MODE_RST);
		else if (wr_fire && dm_we)
		begin
			dm_r.sys_div <= wdata_r[1:0];
			dm_r.out_div <= wdata_r[5:4];
			// Switching source under a live oscillator would glitch it.
			if (!enable_r)
				dm_r.src_ext <= wdata_r[2];
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			enable_r <= EN_SEL_RST[1];
			select_r <= EN_SEL_RST[0];
		end
		else if (sys_reset)
		begin
			enable_r <= EN_SEL_RST[1];
			select_r <= EN_SEL_RST[0];
		end
		else if (wr_fire && es_we)
		begin
			enable_r <= es_wd[1];
			select_r <= es_wd[0] & es_wd[1];
		end
	end

	// ==========================================================
	// Stop mode and the low-speed oscillator.
	logic       stop_r;
	logic [8:0] ls_cnt_r;
	logic [8:0] ls_lim_r;
	logic       ls_ready_r;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			stop_r <= 1'b0;
		else if (sys_reset || wake_irq)
			stop_r <= 1'b0;
		else if (stop_req)
			stop_r <= 1'b1;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			lsosc_run <= 1'b1;
		else
			lsosc_run <= sys_reset || wake_irq || !(stop_r || stop_req);
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ls_cnt_r   <= 9'h000;
			ls_lim_r   <= LS_RESET_WAIT;
			ls_ready_r <= 1'b0;
		end
		else if (sys_reset)
		begin
			ls_cnt_r   <= 9'h000;
			ls_lim_r   <= LS_RESET_WAIT;
			ls_ready_r <= 1'b0;
		end
		else if (stop_r)
		begin
			ls_cnt_r   <= 9'h000;
			ls_lim_r   <= LS_WAKE_WAIT;
			ls_ready_r <= 1'b0;
		end
		else if (!ls_ready_r && rise[0])
		begin
			ls_cnt_r <= ls_cnt_r + 9'h001;
			if (ls_cnt_r + 9'h001 == ls_lim_r)
				ls_ready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			low_speed_clock <= 1'b0;
		else
			low_speed_clock <= ls_ready_r & sync2_r[0];
	end

	// ==========================================================
	// Fast oscillator source, stabilisation and dividers.
	logic        osc_on;
	logic        osc_lvl;
	logic        osc_rise;
	logic [13:0] hs_cnt_r;
	logic [13:0] hs_lim;
	logic        hs_ready_r;
	logic [2:0]  div_cnt_r;
	logic [1:0]  sys_code;

	assign osc_on  = enable_r && !stop_r;
	// Port A takes priority when both pins are set up as clock inputs.
	assign osc_lvl = !dm_r.src_ext ? sync2_r[1] :
	                 external_clock_input_a_cfg   ? sync2_r[2] :
	                 external_clock_input_b_cfg   ? sync2_r[3] : 1'b0;
	assign osc_rise = !dm_r.src_ext ? rise[1] :
	                  external_clock_input_a_cfg   ? rise[2] :
	                  external_clock_input_b_cfg   ? rise[3] : 1'b0;
	assign hs_lim  = dm_r.src_ext ? EXT_WAIT : PLL_WAIT;
	assign sys_code = (dm_r.sys_div == DIV_1 && !dm_r.src_ext) ?
	                  DIV_2 : dm_r.sys_div;

	function automatic logic tap(input logic [1:0] code,
	                             input logic [2:0] cnt,
	                             input logic       lvl);
		unique case (code)
			DIV_1: tap = lvl;
			DIV_2: tap = cnt[0];
			DIV_4: tap = cnt[1];
			DIV_8: tap = cnt[2];
		endcase
	endfunction

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pll_run       <= 1'b0;
			external_clock_input_a_taken <= 1'b0;
			external_clock_input_b_taken <= 1'b0;
		end
		else
		begin
			// The analog loop locks to the low-speed reference times 512.
			pll_run       <= osc_on && !dm_r.src_ext;
			external_clock_input_a_taken <= dm_r.src_ext && external_clock_input_a_cfg;
			external_clock_input_b_taken <= dm_r.src_ext && external_clock_input_b_cfg &&
			                 !external_clock_input_a_cfg;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hs_cnt_r   <= 14'h0000;
			hs_ready_r <= 1'b0;
		end
		else if (!osc_on)
		begin
			hs_cnt_r   <= 14'h0000;
			hs_ready_r <= 1'b0;
		end
		else if (!hs_ready_r && osc_rise)
		begin
			hs_cnt_r <= hs_cnt_r + 14'h0001;
			if (hs_cnt_r + 14'h0001 == hs_lim)
				hs_ready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			div_cnt_r <= 3'h0;
		else if (!hs_ready_r)
			div_cnt_r <= 3'h0;
		else if (osc_rise)
			div_cnt_r <= div_cnt_r + 3'h1;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			high_speed_clock  <= 1'b0;
			fast_output_clock <= 1'b0;
		end
		else
		begin
			high_speed_clock  <= hs_ready_r &
			                     tap(sys_code, div_cnt_r, osc_lvl);
			fast_output_clock <= hs_ready_r &
			                     tap(dm_r.out_div, div_cnt_r,
			                         osc_lvl);
		end
	end

	// ==========================================================
	// Lock detector: PLL edges counted over one reference period.
	logic [9:0] lock_cnt_r;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			lock_cnt_r <= 10'h000;
			lock_r     <= 1'b0;
		end
		else if (!pll_run)
		begin
			lock_cnt_r <= 10'h000;
			lock_r     <= 1'b0;
		end
		else if (rise[0])
		begin
			lock_cnt_r <= 10'h000;
			lock_r     <= lock_cnt_r >= LOCK_LO &&
			              lock_cnt_r <= LOCK_HI;
		end
		else if (rise[1] && lock_cnt_r != 10'h3ff)
			lock_cnt_r <= lock_cnt_r + 10'h001;
	end

	// ==========================================================
	// System clock switch: leave the old source only while it is low.
	sw_state_t sw_state_r;
	logic      want_hs;

	assign want_hs = select_r && enable_r;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sw_state_r   <= SW_LS;
			system_clock <= 1'b0;
		end
		else
		begin
			unique case (sw_state_r)
				SW_LS:
				begin
					system_clock <= low_speed_clock;
					if (want_hs && !low_speed_clock && !system_clock)
					begin
						sw_state_r   <= SW_PARK;
						system_clock <= 1'b0;
					end
				end
				SW_HS:
				begin
					system_clock <= high_speed_clock;
					if (!want_hs && !high_speed_clock && !system_clock)
					begin
						sw_state_r   <= SW_PARK;
						system_clock <= 1'b0;
					end
				end
				SW_PARK:
				begin
					system_clock <= 1'b0;
					if (want_hs && hs_ready_r && !high_speed_clock)
						sw_state_r <= SW_HS;
					else if (!want_hs && ls_ready_r && !low_speed_clock)
						sw_state_r <= SW_LS;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			cpu_hold <= 1'b1;
		else
			cpu_hold <= (sw_state_r == SW_PARK) ||
			            (sw_state_r == SW_HS && !hs_ready_r) ||
			            (sw_state_r == SW_LS && !ls_ready_r);
	end

	// ==========================================================
	// Checks.
	chk_mode_write_lock: assert property (@(posedge clock) disable iff (!rst_b)
		$changed(dm_r.src_ext) |-> !$past(enable_r) || $past(sys_reset))
		else $error("mode bit changed while oscillator enabled");
	chk_select_forced: assert property (@(posedge clock) disable iff (!rst_b)
		!enable_r |-> !select_r)
		else $error("select set while oscillator disabled");
	chk_lock_needs_pll: assert property (@(posedge clock) disable iff (!rst_b)
		!osc_on |-> ##2 !lock_r)
		else $error("lock flag high with PLL stopped");
	chk_ls_wait_count: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(ls_ready_r) |-> $past(ls_cnt_r) + 9'h001 == $past(ls_lim_r))
		else $error("low-speed clock released early");
	chk_hs_wait_count: assert property (@(posedge clock) disable iff (!rst_b)
		$rose(hs_ready_r) |->
		$past(hs_cnt_r) + 14'h0001 == (dm_r.src_ext ? EXT_WAIT : PLL_WAIT))
		else $error("fast clock released early");
	chk_stop_halts: assert property (@(posedge clock) disable iff (!rst_b)
		stop_req && !wake_irq && !sys_reset |=> !lsosc_run ##1 !ls_ready_r)
		else $error("oscillator kept running in stop");
	chk_switch_low: assert property (@(posedge clock) disable iff (!rst_b)
		$changed(sw_state_r) |-> !system_clock && !$past(system_clock))
		else $error("system clock switched while high");
	chk_park_holds: assert property (@(posedge clock) disable iff (!rst_b)
		sw_state_r == SW_PARK |=> cpu_hold)
		else $error("cpu not held while parked");
	chk_pin_priority: assert property (@(posedge clock) disable iff (!rst_b)
		external_clock_input_b_taken |-> !external_clock_input_a_taken && !$past(external_clock_input_a_cfg))
		else $error("port-B pin taken over port-A");
	chk_pll_pins_free: assert property (@(posedge clock) disable iff (!rst_b)
		!dm_r.src_ext |=> !external_clock_input_a_taken && !external_clock_input_b_taken)
		else $error("clock pin taken in PLL mode");

endmodule

/* File: bench/osc_source.sv */
// Behavioural oscillators and external clock source for the clock generator.
module osc_source
(
	input  wire logic        clock,
	input  wire logic        lsosc_run,
	input  wire logic        pll_run,
	input  wire logic        ext_on,
	input  wire logic [10:0] ls_half,
	output logic             lsosc_pin,
	output logic             pll_pin,
	output logic             external_clock_input_a_pin,
	output logic             external_clock_input_b_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int c[4];
	initial
	begin
		{lsosc_pin, pll_pin, external_clock_input_a_pin, external_clock_input_b_pin} = 4'h0;
		c = '{0, 0, 0, 0};
	end
	// =========================================================
	// Sources
	// A stopped source holds its level, as a halted cell does.
	// With ls_half at 1024 the PLL runs 512 times the reference.
	// Port B runs at another rate, so taking it would show.
	always @(posedge clock)
	begin
		if (lsosc_run)
		begin
			c[0] <= (c[0] + 1) % ls_half;
			if (c[0] + 1 >= ls_half) lsosc_pin <= ~lsosc_pin;
		end
		if (pll_run)
		begin
			c[1] <= (c[1] + 1) % 2;
			if (c[1] == 1) pll_pin <= ~pll_pin;
		end
		if (ext_on)
		begin
			c[2] <= (c[2] + 1) % 4;
			c[3] <= (c[3] + 1) % 3;
			if (c[2] == 3) external_clock_input_a_pin <= ~external_clock_input_a_pin;
			if (c[3] == 2) external_clock_input_b_pin <= ~external_clock_input_b_pin;
		end
	end
endmodule

/* File: bench/testbench.sv */
// Register-level testbench for the clock generator.
module testbench
	import clock_gen_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HS = 0, OUT = 1, SYS = 2, LSP = 3, LSC = 4, PLL = 5, CKA = 6;
	localparam logic [17:0] A_DM  = {IDX_DIV_MODE, 2'b00};
	localparam logic [17:0] A_ES  = {IDX_EN_SEL, 2'b00};
	localparam logic [17:0] A_BAD = 18'h3c010;
	logic        clock, rst_b, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, lsosc_pin;
	logic        pll_pin, external_clock_input_a_pin, external_clock_input_b_pin, external_clock_input_a_cfg, external_clock_input_b_cfg;
	logic        sys_reset, stop_req, wake_irq, lsosc_run, pll_run, ext_on;
	logic        external_clock_input_a_taken, external_clock_input_b_taken, low_speed_clock, cpu_hold;
	logic        high_speed_clock, fast_output_clock, system_clock;
	logic [17:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [10:0] ls_half;
	logic [6:0]  mon, mon_q;
	int          cnt[7], d[7], n_errors, num_checks;

	clock_gen #(.PLL_WAIT(14'h0010)) DUT
	(
		.clock(clock), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.lsosc_pin(lsosc_pin), .pll_pin(pll_pin),
		.external_clock_input_a_pin(external_clock_input_a_pin), .external_clock_input_b_pin(external_clock_input_b_pin),
		.external_clock_input_a_cfg(external_clock_input_a_cfg), .external_clock_input_b_cfg(external_clock_input_b_cfg),
		.sys_reset(sys_reset), .stop_req(stop_req), .wake_irq(wake_irq),
		.lsosc_run(lsosc_run), .pll_run(pll_run),
		.external_clock_input_a_taken(external_clock_input_a_taken), .external_clock_input_b_taken(external_clock_input_b_taken),
		.low_speed_clock(low_speed_clock),
		.high_speed_clock(high_speed_clock),
		.fast_output_clock(fast_output_clock),
		.system_clock(system_clock), .cpu_hold(cpu_hold)
	);

	osc_source partner
	(
		.clock(clock), .lsosc_run(lsosc_run), .pll_run(pll_run),
		.ext_on(ext_on), .ls_half(ls_half), .lsosc_pin(lsosc_pin),
		.pll_pin(pll_pin), .external_clock_input_a_pin(external_clock_input_a_pin),
		.external_clock_input_b_pin(external_clock_input_b_pin)
	);

	// =========================================================
	// Edge counters
	assign mon = {external_clock_input_a_pin, pll_pin, low_speed_clock, lsosc_pin,
		system_clock, fast_output_clock, high_speed_clock};
	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		mon_q <= mon;
		for (int i = 0; i < 7; i++)
			if (mon[i] && !mon_q[i]) cnt[i] <= cnt[i] + 1;
	end

	// =========================================================
	// Tasks
	task tally_and_finish();
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task expire();
		n_errors++;
		tally_and_finish();
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task near(input string s, input int e, input int g, input int t);
		num_checks++;
		if (g < e - t || g > e + t)
		begin
			n_errors++;
			$display("unexpected %s: expected %0d, seen %0d", s, e, g);
		end
	endtask
	task wr(input logic [17:0] a, input logic [31:0] v, input logic [3:0] s,
		input logic [1:0] er);
		int k;
		@(posedge clock);
		awaddr <= a;
		wdata <= v;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 64; k++)
		begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		if (k == 64) expire();
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask
	task rd(input logic [17:0] a, input logic [31:0] ev, input logic [1:0] er);
		int k;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 64; k++)
		begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		if (k == 64) expire();
		chk("rdata", ev, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask
	// Counts reference edges until the watched clock first rises.
	task wait_rise(input int w, input int r, input int e, input string s);
		int bw, br, k;
		bw = cnt[w];
		br = cnt[r];
		for (k = 0; k < 20000 && cnt[w] == bw; k++)
			@(posedge clock);
		if (k == 20000) expire();
		near(s, e, cnt[r] - br, 2);
	endtask
	// Settles for a while after a change, then counts rises.
	task measure(input int n);
		int b[7];
		repeat (32) @(posedge clock);
		b = cnt;
		repeat (n) @(posedge clock);
		foreach (d[i]) d[i] = cnt[i] - b[i];
	endtask
	task pulse(input int w);
		@(posedge clock);
		{sys_reset, wake_irq, stop_req} <= 3'b001 << w;
		@(posedge clock);
		{sys_reset, wake_irq, stop_req} <= 3'b000;
	endtask

	// =========================================================
	// Sequence
	initial
	begin
		{clock, rst_b, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{sys_reset, stop_req, wake_irq, ext_on} = 4'h0;
		{external_clock_input_a_cfg, external_clock_input_b_cfg} = 2'h0;
		{awaddr, araddr, wdata, wstrb} = '0;
		ls_half = 11'h002;
		repeat (6) @(posedge clock);
		chk("cpu_hold", 1, cpu_hold);
		rst_b <= 1'b1;
		wait_rise(LSC, LSP, 257, "reset wait");
		measure(512);
		near("sys vs ls", d[LSP], d[SYS], 1);
		chk("cpu_hold", 0, cpu_hold);
		rd(A_DM, 32'h0000003b, RESP_OKAY);
		rd(A_ES, 32'h00000000, RESP_OKAY);
		wr(A_ES, 32'h01, 4'h1, RESP_OKAY);
		rd(A_ES, 32'h00000000, RESP_OKAY);
		wr(A_DM, 32'hf5, 4'h1, RESP_OKAY);
		rd(A_DM, 32'h0000003d, RESP_OKAY);
		wr(A_BAD, 32'hff, 4'hf, RESP_DECERR);
		rd(A_BAD, 32'h0, RESP_DECERR);
		// External source on both pins, word write enables it.
		{ext_on, external_clock_input_a_cfg, external_clock_input_b_cfg} <= 3'h7;
		wr(A_DM, 32'h0000020c, 4'h3, RESP_OKAY);
		wait_rise(HS, CKA, 129, "ext wait");
		chk("a taken", 1, external_clock_input_a_taken);
		chk("b taken", 0, external_clock_input_b_taken);
		external_clock_input_a_cfg <= 1'b0;
		repeat (4) @(posedge clock);
		chk("b alone", 1, external_clock_input_b_taken);
		external_clock_input_a_cfg <= 1'b1;
		wr(A_DM, 32'h08, 4'h1, RESP_OKAY);
		rd(A_DM, 32'h0000020c, RESP_OKAY);
		for (int c = 0; c < 4; c++)
		begin
			wr(A_DM, {24'h0, 2'b00, c[1:0], 2'b11, c[1:0]}, 4'h1, RESP_OKAY);
			measure(1024);
			near("hs div", 128 >> c, d[HS], 1);
			near("out div", 128 >> c, d[OUT], 1);
		end
		wr(A_ES, 32'h03, 4'h1, RESP_OKAY);
		measure(1024);
		chk("cpu_hold", 0, cpu_hold);
		near("sys vs hs", d[HS], d[SYS], 1);
		pulse(0);
		measure(200);
		chk("ls run", 0, lsosc_run);
		near("ls in stop", 0, d[LSC], 0);
		near("hs in stop", 0, d[HS], 0);
		pulse(1);
		wait_rise(LSC, LSP, 33, "wake wait");
		wr(A_ES, 32'h01, 4'h1, RESP_OKAY);
		rd(A_ES, 32'h00000000, RESP_OKAY);
		// PLL mode, changed only while the fast oscillator is disabled.
		wr(A_DM, 32'h08, 4'h1, RESP_OKAY);
		rd(A_DM, 32'h00000008, RESP_OKAY);
		wr(A_ES, 32'h02, 4'h1, RESP_OKAY);
		wait_rise(HS, PLL, 17, "pll wait");
		chk("pll run", 1, pll_run);
		chk("a taken", 0, external_clock_input_a_taken);
		chk("b taken", 0, external_clock_input_b_taken);
		measure(1024);
		near("hs pll", 128, d[HS], 1);
		near("out pll", 256, d[OUT], 1);
		rd(A_ES, 32'h00000002, RESP_OKAY);
		ls_half <= 11'd1024;
		repeat (7000) @(posedge clock);
		rd(A_ES, 32'h00000082, RESP_OKAY);
		ls_half <= 11'd2;
		pulse(0);
		repeat (50) @(posedge clock);
		pulse(1);
		wait_rise(HS, PLL, 17, "pll rewait");
		wr(A_ES, 32'h00, 4'h1, RESP_OKAY);
		repeat (8) @(posedge clock);
		rd(A_ES, 32'h00000000, RESP_OKAY);
		chk("pll run", 0, pll_run);
		pulse(2);
		rd(A_DM, 32'h0000003b, RESP_OKAY);
		chk("ls run", 1, lsosc_run);
		wait_rise(LSC, LSP, 257, "sys reset wait");
		tally_and_finish();
	end
endmodule
